// ==== hdl/eedac_pkg.sv ====
// Purpose: constants and types of the eeprom dac command block
// Assumes: serial clock idles high, chip select active low
// Notes: register slots are avalon words at byte offsets
package eedac_pkg;
	localparam int WORDS = 128;
	localparam int AW    = 7;
	localparam int DW    = 16;

	localparam logic [7:0] OP_READ    = 8'ha8;
	localparam logic [7:0] OP_WRITE   = 8'ha4;
	localparam logic [7:0] OP_W_ALLOW = 8'ha3;
	localparam logic [7:0] OP_W_PROT  = 8'ha0;
	localparam logic [7:0] OP_PDOWN   = 8'hac;
	localparam logic [7:0] OP_PRESUME = 8'ha6;
	localparam logic [7:0] OP_RECALL  = 8'ha2;

	localparam logic [5:0] BITS_HEAD  = 6'h10;
	localparam logic [5:0] BITS_FRAME = 6'h20;

	localparam logic [3:0] REG_STATUS   = 4'h0;
	localparam logic [3:0] REG_DAC      = 4'h4;
	localparam logic [3:0] REG_MEM_ADDR = 4'h8;
	localparam logic [3:0] REG_MEM_DATA = 4'hc;

	localparam int ST_DAC_ON = 0;
	localparam int ST_W_OK   = 1;
	localparam int ST_BOOTED = 2;

	typedef enum logic [1:0] {
		BOOT_WAIT  = 2'b00,
		BOOT_FIRST = 2'b01,
		BOOT_RUN   = 2'b11
	} eedac_boot_e;

	typedef struct packed {
		logic [5:0] cnt;
		logic       rd;
		logic       vld;
	} eedac_lctl_s;

	typedef struct packed {
		logic [31:0]   sh;
		logic [31:0]   ins;
		logic [AW-1:0] rd_addr;
	} eedac_ldat_s;

	typedef struct packed {
		logic [DW-1:0] out_sh;
		logic          oe;
	} eedac_lout_s;

	typedef struct packed {
		logic [WORDS-1:0][DW-1:0] mem;
		eedac_boot_e   boot;
		logic          w_ok;
		logic          dac_on;
		logic [7:0]    dac0;
		logic [7:0]    dac1;
		logic [DW-1:0] rd_data;
		logic [AW-1:0] ra_s1;
		logic [AW-1:0] ra_s2;
		logic [2:0]    vl_s;
		logic [1:0]    cs_s;
		logic [AW-1:0] mem_addr;
		logic          wait_r;
		logic [31:0]   rdata;
	} eedac_core_s;
endpackage

// ==== hdl/eedac_top.sv ====
// Purpose: serial eeprom with two dac channel settings
// Assumes: serial clock high outside frames, select low per frame
// Notes: link logic runs on the serial clock, control and output flops reset by select high
`timescale 1ns/1ps
`default_nettype none
module eedac_top (
	// system
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	// avalon slave
	input  wire logic [3:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	// serial link
	input  wire logic        serial_clock_pin_in,
	input  wire logic        chip_select_n_in,
	input  wire logic        serial_in_pin_in,
	output logic             serial_out_pin_out,
	output logic             serial_out_oe_out,
	// dac channels
	output logic      [7:0]  dac_channel_zero_out,
	output logic      [7:0]  dac_channel_one_out,
	output logic             dac_enable_out
);
	eedac_pkg::eedac_lctl_s lk_reg;
	eedac_pkg::eedac_lctl_s lk_next;
	eedac_pkg::eedac_ldat_s ld_reg;
	eedac_pkg::eedac_ldat_s ld_next;
	eedac_pkg::eedac_lout_s lf_reg;
	eedac_pkg::eedac_lout_s lf_next;
	eedac_pkg::eedac_core_s st_reg;
	eedac_pkg::eedac_core_s st_next;
	logic [5:0]             cnt_inc;

	localparam eedac_pkg::eedac_core_s CORE_RST = '{
		boot:    eedac_pkg::BOOT_WAIT,
		wait_r:  1'b1,
		cs_s:    2'b11,
		default: '0
	};

	// ----------------------------------------------------------
	// link input side, rising serial clock
	// ----------------------------------------------------------
	always_comb begin
		lk_next = lk_reg;
		ld_next = ld_reg;
		cnt_inc = lk_reg.cnt + 6'h01;
		ld_next.sh = {ld_reg.sh[30:0], serial_in_pin_in};
		if (lk_reg.rd || lk_reg.cnt != eedac_pkg::BITS_FRAME) begin
			lk_next.cnt = cnt_inc;
		end
		if (!lk_reg.rd && cnt_inc == eedac_pkg::BITS_HEAD &&
			ld_next.sh[15:8] == eedac_pkg::OP_READ) begin
			lk_next.rd      = 1'b1;
			ld_next.rd_addr = ld_next.sh[7:1];
		end
		if (lk_reg.rd && cnt_inc == eedac_pkg::BITS_FRAME) begin
			ld_next.rd_addr = ld_reg.rd_addr + 7'h01;
			lk_next.cnt     = eedac_pkg::BITS_HEAD;
		end
		if (!lk_reg.rd && cnt_inc == eedac_pkg::BITS_FRAME) begin
			ld_next.ins = ld_next.sh;
			lk_next.vld = 1'b1;
		end
	end

	always_ff @(posedge serial_clock_pin_in or
		posedge chip_select_n_in) begin
		if (chip_select_n_in) begin
			lk_reg <= '0;
		end else begin
			lk_reg <= lk_next;
		end
	end

	always_ff @(posedge serial_clock_pin_in) begin
		ld_reg <= ld_next;
	end

	// ----------------------------------------------------------
	// link output side, falling serial clock
	// ----------------------------------------------------------
	always_comb begin
		lf_next = lf_reg;
		lf_next.out_sh = {lf_reg.out_sh[14:0], 1'b0};
		if (lk_reg.rd && lk_reg.cnt == eedac_pkg::BITS_HEAD) begin
			lf_next.oe     = 1'b1;
			lf_next.out_sh = st_reg.rd_data;
		end
	end

	always_ff @(negedge serial_clock_pin_in or
		posedge chip_select_n_in) begin
		if (chip_select_n_in) begin
			lf_reg <= '0;
		end else begin
			lf_reg <= lf_next;
		end
	end

	// ----------------------------------------------------------
	// core side
	// ----------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.cs_s  = {st_reg.cs_s[0], chip_select_n_in};
		st_next.vl_s  = {st_reg.vl_s[1:0], lk_reg.vld};
		st_next.ra_s1 = ld_reg.rd_addr;
		st_next.ra_s2 = st_reg.ra_s1;
		st_next.rd_data = st_reg.mem[st_reg.ra_s2];

		// power-up readout
		case (st_reg.boot)
			eedac_pkg::BOOT_WAIT: begin
				if (!st_reg.cs_s[1]) begin
					st_next.boot   = eedac_pkg::BOOT_FIRST;
					st_next.dac_on = 1'b1;
					st_next.dac0   = st_reg.mem[0][15:8];
					st_next.dac1   = st_reg.mem[0][7:0];
				end
			end
			eedac_pkg::BOOT_FIRST: begin
				if (st_reg.cs_s[1]) begin
					st_next.boot = eedac_pkg::BOOT_RUN;
				end
			end
			eedac_pkg::BOOT_RUN: begin
				st_next.boot = eedac_pkg::BOOT_RUN;
			end
			default: begin
				st_next.boot = eedac_pkg::BOOT_WAIT;
			end
		endcase

		// avalon slave
		st_next.wait_r = 1'b1;
		if ((avs_read_in || avs_write_in) && st_reg.wait_r) begin
			st_next.wait_r = 1'b0;
			st_next.rdata  = '0;
			if (avs_read_in) begin
				case (avs_address_in)
					eedac_pkg::REG_STATUS: begin
						st_next.rdata[eedac_pkg::ST_DAC_ON] =
							st_reg.dac_on;
						st_next.rdata[eedac_pkg::ST_W_OK] =
							st_reg.w_ok;
						st_next.rdata[eedac_pkg::ST_BOOTED] =
							st_reg.boot == eedac_pkg::BOOT_RUN;
					end
					eedac_pkg::REG_DAC: begin
						st_next.rdata[15:0] =
							{st_reg.dac0, st_reg.dac1};
					end
					eedac_pkg::REG_MEM_ADDR: begin
						st_next.rdata[6:0] = st_reg.mem_addr;
					end
					eedac_pkg::REG_MEM_DATA: begin
						st_next.rdata[15:0] =
							st_reg.mem[st_reg.mem_addr];
					end
					default: begin
						st_next.rdata = '0;
					end
				endcase
			end
		end else if (avs_write_in && !st_reg.wait_r) begin
			case (avs_address_in)
				eedac_pkg::REG_MEM_ADDR: begin
					st_next.mem_addr = avs_writedata_in[6:0];
				end
				eedac_pkg::REG_MEM_DATA: begin
					st_next.mem[st_reg.mem_addr] =
						avs_writedata_in[15:0];
				end
				default: begin
					st_next.mem_addr = st_reg.mem_addr;
				end
			endcase
		end

		// instruction execution
		if (st_reg.vl_s[1] && !st_reg.vl_s[2] &&
			st_reg.boot == eedac_pkg::BOOT_RUN) begin
			case (ld_reg.ins[31:24])
				eedac_pkg::OP_WRITE: begin
					if (st_reg.w_ok) begin
						st_next.mem[ld_reg.ins[23:17]] =
							ld_reg.ins[15:0];
					end
					if (ld_reg.ins[23:17] == 7'h00 &&
						st_reg.dac_on) begin
						st_next.dac0 = ld_reg.ins[15:8];
						st_next.dac1 = ld_reg.ins[7:0];
					end
				end
				eedac_pkg::OP_W_ALLOW: begin
					st_next.w_ok = 1'b1;
				end
				eedac_pkg::OP_W_PROT: begin
					st_next.w_ok = 1'b0;
				end
				eedac_pkg::OP_PDOWN: begin
					st_next.dac_on = 1'b0;
				end
				eedac_pkg::OP_PRESUME: begin
					st_next.dac_on = 1'b1;
				end
				eedac_pkg::OP_RECALL: begin
					if (st_reg.dac_on) begin
						st_next.dac0 =
							st_reg.mem[ld_reg.ins[23:17]][15:8];
						st_next.dac1 =
							st_reg.mem[ld_reg.ins[23:17]][7:0];
					end
				end
				default: begin
					st_next.w_ok = st_reg.w_ok;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			st_reg <= CORE_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------
	// outputs
	// ----------------------------------------------------------
	assign avs_readdata_out     = st_reg.rdata;
	assign avs_waitrequest_out  = st_reg.wait_r;
	assign serial_out_pin_out   = lf_reg.out_sh[15];
	assign serial_out_oe_out    = lf_reg.oe;
	assign dac_channel_zero_out = st_reg.dac0;
	assign dac_channel_one_out  = st_reg.dac1;
	assign dac_enable_out       = st_reg.dac_on;
endmodule
`default_nettype wire

// ==== sim/eedac_assertions.sv ====
// Purpose: port assertions of the eeprom dac block
// Assumes: bound to eedac_top
// Notes: one avalon request at a time
`timescale 1ns/1ps
`default_nettype none
module eedac_assertions (
	// watched ports
	input wire logic        clk_in,
	input wire logic        srst_in,
	input wire logic [3:0]  avs_address_in,
	input wire logic        avs_read_in,
	input wire logic        avs_write_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic        avs_waitrequest_out,
	input wire logic        chip_select_n_in,
	input wire logic        serial_out_pin_out,
	input wire logic        serial_out_oe_out,
	input wire logic [7:0]  dac_channel_zero_out,
	input wire logic [7:0]  dac_channel_one_out,
	input wire logic        dac_enable_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);
	wire        req = avs_read_in || avs_write_in;
	wire [15:0] dac = {dac_channel_zero_out, dac_channel_one_out};
	sequence s_ans;
		!avs_waitrequest_out ##1 avs_waitrequest_out;
	endsequence
	a_req_answer: assert property (req && avs_waitrequest_out |=> s_ans)
		else $error("answer");
	a_idle_wait: assert property (!req |=> avs_waitrequest_out)
		else $error("idle");
	a_data_holds: assert property (!req |=> $stable(avs_readdata_out))
		else $error("data");
	a_upper_zero: assert property (!avs_waitrequest_out
		|-> avs_readdata_out[31:16] == 16'h0) else $error("upper");
	a_dac_read: assert property (!avs_waitrequest_out && $past(avs_read_in)
		&& $past(avs_address_in) == eedac_pkg::REG_DAC
		|-> avs_readdata_out[15:0] == dac) else $error("dac reg");
	a_oe_idle: assert property (chip_select_n_in |-> !serial_out_oe_out)
		else $error("oe");
	a_out_quiet: assert property (!serial_out_oe_out |-> !serial_out_pin_out)
		else $error("out");
	a_dac_hold: assert property (!dac_enable_out |=>
		dac_enable_out || $stable(dac)) else $error("hold");
	a_reset_state: assert property (disable iff (1'b0) srst_in |=>
		avs_waitrequest_out && !dac_enable_out && dac == 16'h0)
		else $error("reset");
endmodule
`default_nettype wire

// ==== sim/eedac_link.sv ====
// Purpose: serial master sending instruction frames
// Assumes: clock idles high, select low per frame
// Notes: released data line shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module eedac_link (
	// serial pins
	output logic      sck_out,
	output logic      cs_n_out,
	output logic      sdi_out,
	input  wire logic sdo_in
);
	// select rises after time zero so the link flops see a reset edge
	initial begin
		sck_out = 1'b1;
		sdi_out = 1'b0;
		#1 cs_n_out = 1'b1;
	end
	task automatic xfer(input logic [31:0] w, input int n,
		output logic [31:0] r);
		r = 32'h0;
		#13 cs_n_out = 1'b0;
		#100;
		for (int i = 0; i < n; i++) begin
			sck_out = 1'b0;
			sdi_out = (i < 32) ? w[31 - i] : ~sdi_out;
			#80 r = {r[30:0], sdo_in};
			sck_out = 1'b1;
			#80;
		end
		#40 cs_n_out = 1'b1;
		sdi_out = ~sdi_out;
		#200;
	endtask
endmodule
`default_nettype wire

// ==== sim/test_serial_eeprom_dac_command_control.sv ====
// Purpose: self-checking bench of the eeprom dac block
// Assumes: link model drives the serial pins
// Notes: expected state kept in plain variables
`timescale 1ns/1ps
`default_nettype none
module test_serial_eeprom_dac_command_control;
	logic        clk_in = 1'b0;
	logic        srst_in = 1'b1;
	logic [3:0]  addr = 4'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdata;
	logic        wreq, sck, cs_n, sdi, sdo, oe, en, on, wok, b;
	logic [7:0]  c0, c1, d0, d1;
	logic [15:0] m [128];
	int          failures = 0;
	int          checks = 0;
	int          seed = 57;
	always #2 clk_in = ~clk_in;
	eedac_top dut (
		.clk_in, .srst_in,
		.avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wd), .avs_readdata_out(rdata),
		.avs_waitrequest_out(wreq), .serial_clock_pin_in(sck),
		.chip_select_n_in(cs_n), .serial_in_pin_in(sdi),
		.serial_out_pin_out(sdo), .serial_out_oe_out(oe),
		.dac_channel_zero_out(c0), .dac_channel_one_out(c1),
		.dac_enable_out(en)
	);
	eedac_link lm (.sck_out(sck), .cs_n_out(cs_n), .sdi_out(sdi),
		.sdo_in(sdo));
	task finish_test;
		if (failures == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH %0t %h %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic [3:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_in);
		addr <= a;
		rd <= !w;
		wr <= w;
		wd <= d;
		do @(posedge clk_in); while (wreq !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic st;
		logic [31:0] q;
		bus(eedac_pkg::REG_STATUS, 1'b0, 32'h0, q);
		chk(q, {29'h0, b, wok, on});
		bus(eedac_pkg::REG_DAC, 1'b0, 32'h0, q);
		chk(q, {16'h0, d0, d1});
		chk({15'h0, c0, c1, en}, {15'h0, d0, d1, on});
	endtask
	task automatic mchk(input logic [6:0] a);
		logic [31:0] q;
		bus(eedac_pkg::REG_MEM_ADDR, 1'b1, {25'h0, a}, q);
		bus(eedac_pkg::REG_MEM_DATA, 1'b0, 32'h0, q);
		chk(q, {16'h0, m[a]});
	endtask
	task automatic cmd(input logic [7:0] op, input logic [6:0] a,
		input logic [15:0] d);
		logic [31:0] r;
		lm.xfer({op, a, 1'b0, d}, 32, r);
		case (op)
			eedac_pkg::OP_WRITE: begin
				if (wok) m[a] = d;
				if (a == 7'h0 && on) {d0, d1} = d;
			end
			eedac_pkg::OP_W_ALLOW: wok = 1'b1;
			eedac_pkg::OP_W_PROT: wok = 1'b0;
			eedac_pkg::OP_PDOWN: on = 1'b0;
			eedac_pkg::OP_PRESUME: on = 1'b1;
			eedac_pkg::OP_RECALL: if (on) {d0, d1} = m[a];
			default: ;
		endcase
	endtask
	initial begin
		#250000;
		failures++;
		finish_test();
	end
	initial begin
		logic [31:0] q;
		logic [6:0]  a;
		repeat (8) @(posedge clk_in);
		srst_in <= 1'b0;
		{on, wok, b, d0, d1} = '0;
		for (int i = 0; i < 128; i++) m[i] = 16'h0;
		st();
		bus(4'h2, 1'b0, 32'h0, q);
		chk(q, 32'h0);
		for (int i = 0; i < 4; i++) begin
			a = (i == 3) ? 7'h7f : 7'(i);
			m[a] = 16'($random(seed));
			bus(eedac_pkg::REG_MEM_ADDR, 1'b1, {25'h0, a}, q);
			bus(eedac_pkg::REG_MEM_DATA, 1'b1, {16'h0, m[a]}, q);
		end
		lm.xfer({eedac_pkg::OP_W_ALLOW, 24'h0}, 32, q);
		{b, on} = 2'h3;
		{d0, d1} = m[0];
		st();
		cmd(eedac_pkg::OP_WRITE, 7'h1, 16'($random(seed)));
		mchk(7'h1);
		cmd(eedac_pkg::OP_WRITE, 7'h0, 16'($random(seed)));
		st();
		mchk(7'h0);
		for (int k = 0; k < 2; k++) begin
			lm.xfer({eedac_pkg::OP_READ, 8'hfe, 16'h0}, 48, q);
			chk(q, {m[127], m[0]});
			cmd(eedac_pkg::OP_W_ALLOW, 7'h0, 16'h0);
		end
		cmd(eedac_pkg::OP_WRITE, 7'h2, 16'($random(seed)));
		cmd(eedac_pkg::OP_WRITE, 7'h1, 16'($random(seed)));
		mchk(7'h2);
		mchk(7'h1);
		cmd(eedac_pkg::OP_RECALL, 7'h1, 16'h0);
		st();
		cmd(eedac_pkg::OP_PDOWN, 7'h0, 16'h0);
		st();
		cmd(eedac_pkg::OP_RECALL, 7'h2, 16'h0);
		cmd(eedac_pkg::OP_WRITE, 7'h0, 16'($random(seed)));
		st();
		mchk(7'h0);
		lm.xfer({eedac_pkg::OP_PRESUME, 24'h0}, 16, q);
		st();
		cmd(eedac_pkg::OP_PRESUME, 7'h0, 16'h0);
		st();
		cmd(eedac_pkg::OP_W_PROT, 7'h0, 16'h0);
		cmd(eedac_pkg::OP_WRITE, 7'h2, 16'($random(seed)));
		mchk(7'h2);
		finish_test();
	end
endmodule
bind eedac_top eedac_assertions u_chk (
	.clk_in, .srst_in, .avs_address_in, .avs_read_in, .avs_write_in,
	.avs_readdata_out, .avs_waitrequest_out, .chip_select_n_in,
	.serial_out_pin_out, .serial_out_oe_out, .dac_channel_zero_out,
	.dac_channel_one_out, .dac_enable_out
);
`default_nettype wire
